// *** component_bin_sorter.sv ***
// Limit-based bin sorter with an AXI4-Lite register slave
module component_bin_sorter
	import sorter_pkg::*;
#(
	parameter int NUM_BINS = 9
) (
	// Clock, reset and clock enable
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// AXI4-Lite write address and data
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	// AXI4-Lite write response
	output logic                   bvalid,
	input  wire logic              bready,
	output logic [1:0]             bresp,
	// AXI4-Lite read
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	// Measurement in
	input  wire logic              meas_valid,
	input  wire meas_t             meas,
	// Decision to the handler
	output result_t                decision
);

	// Address to register index; misaligned or unmapped gives BAD_IDX
	function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		off = a - LIM_BASE_ADDR;
		if (a[1:0] != 2'b00)
			return BAD_IDX;
		if (a < LIM_BASE_ADDR)
			return (a <= STATUS_ADDR) ? 6'(a[ADDR_W-1:2]) : BAD_IDX;
		if (int'(off[ADDR_W-1:2]) < 2 * NUM_BINS)
			return LIM_IDX + 6'(off[ADDR_W-1:2]);
		return BAD_IDX;
	endfunction

	// Byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	// Lowest set bit wins, giving a 1-based bin number
	function automatic logic [3:0] first_hit(input logic [NUM_BINS-1:0] hit);
		logic [3:0] r;
		r = NO_BIN;
		for (int i = NUM_BINS - 1; i >= 0; i--) begin
			if (hit[i])
				r = 4'(i + 1);
		end
		return r;
	endfunction

	// Configuration state
	limit_mode_t        mode;
	logic               sort_enable;
	logic               aux_enable;
	logic               sec_lo_set;
	logic               sec_hi_set;
	logic [3:0]         bin_count;
	logic signed [31:0] center_value;
	logic signed [31:0] sec_lo;
	logic signed [31:0] sec_hi;
	logic signed [31:0] lim_lo [NUM_BINS];
	logic signed [31:0] lim_hi [NUM_BINS];

	// Bus slave state
	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              do_write;
	logic [5:0]        widx;
	logic [5:0]        ridx;
	logic [31:0]       ctrl_word;
	logic [31:0]       next_rdata;
	logic [31:0]       ctrl_next;

	assign do_write = aw_held && w_held && !bvalid;
	assign widx     = reg_index(aw_addr_q);
	assign ridx     = reg_index(araddr);
	assign ctrl_word = {20'h0_0000, bin_count, 2'b00, sec_hi_set, sec_lo_set,
		aux_enable, sort_enable, mode};
	assign ctrl_next = merge(ctrl_word, w_data_q, w_strb_q);

	// Address and data are taken in either order; response once both are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_held   <= 1'b1;
				awready   <= 1'b0;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_held   <= 1'b1;
				wready   <= 1'b0;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= (widx == BAD_IDX || widx == STATUS_IDX) ? RESP_SLVERR : RESP_OKAY;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// Read mux: status shows the last decision
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (ridx)
			CTRL_IDX:   next_rdata = ctrl_word;
			CENTER_IDX: next_rdata = center_value;
			SEC_LO_IDX: next_rdata = sec_lo;
			SEC_HI_IDX: next_rdata = sec_hi;
			STATUS_IDX: next_rdata = {27'h000_0000, decision.valid, decision.bin};
			default: begin
				for (int i = 0; i < NUM_BINS; i++) begin
					if (ridx == LIM_IDX + 6'(2 * i))
						next_rdata = lim_lo[i];
					if (ridx == LIM_IDX + 6'(2 * i + 1))
						next_rdata = lim_hi[i];
				end
			end
		endcase
	end

	// One read in flight; arready drops until the data is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= next_rdata;
				rresp   <= (ridx == BAD_IDX) ? RESP_SLVERR : RESP_OKAY;
			end else if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// Control, center and secondary limit registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode         <= limit_mode_t'(CTRL_RESET[CTRL_MODE_LSB +: 2]);
			sort_enable  <= CTRL_RESET[CTRL_ENABLE];
			aux_enable   <= CTRL_RESET[CTRL_AUX];
			sec_lo_set   <= CTRL_RESET[CTRL_SEC_LO];
			sec_hi_set   <= CTRL_RESET[CTRL_SEC_HI];
			bin_count    <= CTRL_RESET[CTRL_COUNT_LSB +: 4];
			center_value <= '0;
			sec_lo       <= '0;
			sec_hi       <= '0;
		end else if (ce && do_write) begin
			unique case (widx)
				CTRL_IDX: begin
					// Unused mode code 2'b11 falls back to ascending
					mode <= (&ctrl_next[CTRL_MODE_LSB +: 2]) ? ascending_boundary_mode
						: limit_mode_t'(ctrl_next[CTRL_MODE_LSB +: 2]);
					sort_enable <= ctrl_next[CTRL_ENABLE]; // see [RQ4]
					aux_enable  <= ctrl_next[CTRL_AUX];
					sec_lo_set  <= ctrl_next[CTRL_SEC_LO];
					sec_hi_set  <= ctrl_next[CTRL_SEC_HI];
					bin_count   <= ctrl_next[CTRL_COUNT_LSB +: 4];
				end
				// Stored in every mode, used only by deviation modes
				CENTER_IDX: center_value <= merge(center_value, w_data_q, w_strb_q); // see [RQ3]
				SEC_LO_IDX: sec_lo <= merge(sec_lo, w_data_q, w_strb_q);
				SEC_HI_IDX: sec_hi <= merge(sec_hi, w_data_q, w_strb_q);
				default: ;
			endcase
		end
	end

	// Bin limits; in deviation modes a low entry sets a symmetric pair
	logic signed [31:0] entry [NUM_BINS];
	logic signed [31:0] entry_mag [NUM_BINS];
	generate
		for (genvar g = 0; g < NUM_BINS; g++) begin : g_lim
			assign entry[g]     = merge(lim_lo[g], w_data_q, w_strb_q);
			assign entry_mag[g] = entry[g] < 0 ? -entry[g] : entry[g];
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					lim_lo[g] <= '0;
					lim_hi[g] <= '0;
				end else if (ce && do_write) begin
					if (widx == LIM_IDX + 6'(2 * g)) begin
						if (mode != ascending_boundary_mode) begin
							lim_lo[g] <= -entry_mag[g]; // see [RQ12]
							lim_hi[g] <= entry_mag[g];
						end else begin
							lim_lo[g] <= entry[g];
						end
					end
					if (widx == LIM_IDX + 6'(2 * g + 1))
						lim_hi[g] <= merge(lim_hi[g], w_data_q, w_strb_q);
				end
			end
		end
	endgenerate

	// Primary deviation against the center value
	logic signed [32:0] delta;
	logic signed [32:0] abs_center;
	logic signed [65:0] delta_scaled;
	logic [NUM_BINS-1:0] in_bin;
	assign delta        = 33'(meas.primary) - 33'(center_value); // see [RQ2]
	assign abs_center   = center_value < 0 ? -33'(center_value) : 33'(center_value);
	assign delta_scaled = 66'(delta) * 66'(PCT_FULL);

	// Per-bin window test in the selected mode
	generate
		for (genvar g = 0; g < NUM_BINS; g++) begin : g_bin
			logic signed [31:0] eff_lo;
			logic signed [65:0] lo_scaled;
			logic signed [65:0] hi_scaled;
			logic               hit;
			// Ascending chain: only the first bin owns its low edge
			if (g == 0) begin : g_first
				assign eff_lo = lim_lo[0];
			end else begin : g_chain
				assign eff_lo = lim_hi[g-1]; // see [RQ13]
			end
			assign lo_scaled = 66'(lim_lo[g]) * 66'(abs_center);
			assign hi_scaled = 66'(lim_hi[g]) * 66'(abs_center);
			always_comb begin
				unique case (mode) // see [RQ1]
					percent_deviation_mode:
						hit = delta_scaled >= lo_scaled && delta_scaled <= hi_scaled;
					value_deviation_mode:
						hit = delta >= 33'(lim_lo[g]) && delta <= 33'(lim_hi[g]);
					default:
						hit = meas.primary >= eff_lo && meas.primary <= lim_hi[g];
				endcase
			end
			// Bins above the configured count never match
			assign in_bin[g] = hit && (g < int'(bin_count)); // see [RQ5]
		end
	endgenerate

	// Secondary test: fails at or beyond any configured edge
	logic       sec_cfg;
	logic       sec_fail;
	logic [3:0] prim_bin;
	logic [3:0] next_bin;
	assign sec_cfg  = sec_lo_set || sec_hi_set;
	assign sec_fail = (sec_lo_set && meas.secondary <= sec_lo) // see [RQ10]
		|| (sec_hi_set && meas.secondary >= sec_hi); // see [RQ11]
	assign prim_bin = first_hit(in_bin); // see [RQ16]

	// Outcome selection; unconfigured secondary never fails
	always_comb begin
		if (prim_bin == NO_BIN)
			next_bin = REJECT_RESULT; // see [RQ8]
		else if (sec_cfg && sec_fail)
			next_bin = aux_enable ? SEC_FAIL_BIN : REJECT_RESULT; // see [RQ7] see [RQ9]
		else
			next_bin = prim_bin; // see [RQ6]
	end

	// Decision register; disabled sorter stays silent
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			decision <= '{valid: 1'b0, bin: NO_BIN};
		end else if (ce) begin
			decision.valid <= meas_valid && sort_enable; // see [RQ17]
			if (meas_valid && sort_enable)
				decision.bin <= next_bin;
		end
	end

	// Checks on the decision path and on deviation limit entry
	disabled_silent_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ17]
		ce && !sort_enable |=> !decision.valid)
		else $error("decision issued while sorter disabled");

	enabled_answer_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ4]
		ce && sort_enable && meas_valid |=> decision.valid && decision.bin != NO_BIN)
		else $error("enabled sorter gave no decision");

	sec_reject_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ7]
		ce && sort_enable && meas_valid && sec_cfg && sec_fail && !aux_enable
		|=> decision.bin == REJECT_RESULT)
		else $error("secondary failure not rejected");

	prim_miss_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ8]
		ce && sort_enable && meas_valid && in_bin == '0 |=> decision.bin == REJECT_RESULT)
		else $error("primary miss not rejected");

	aux_bin_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ9]
		ce && sort_enable && meas_valid && aux_enable && sec_cfg && sec_fail && in_bin != '0
		|=> decision.bin == SEC_FAIL_BIN)
		else $error("secondary failure missed the extra bin");

	no_sec_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ6]
		ce && sort_enable && meas_valid && !sec_cfg |=> decision.bin != SEC_FAIL_BIN)
		else $error("extra bin used without secondary limits");

	lo_edge_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ10]
		ce && sort_enable && meas_valid && aux_enable && sec_lo_set && in_bin != '0
		&& meas.secondary <= sec_lo |=> decision.bin == SEC_FAIL_BIN)
		else $error("secondary at lower limit missed the extra bin");

	hi_edge_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ11]
		ce && sort_enable && meas_valid && aux_enable && sec_hi_set && in_bin != '0
		&& meas.secondary >= sec_hi |=> decision.bin == SEC_FAIL_BIN)
		else $error("secondary at upper limit missed the extra bin");

	first_bin_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ16]
		ce && sort_enable && meas_valid && in_bin[0] && !(sec_cfg && sec_fail)
		|=> decision.bin == 4'h1)
		else $error("first matching bin not chosen");

	sym_entry_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ12]
		ce && do_write && widx == LIM_IDX && mode != ascending_boundary_mode
		|=> lim_hi[0] == -lim_lo[0] && lim_hi[0] >= 0)
		else $error("deviation entry not symmetric");

	chain_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ13]
		ce && meas_valid && sort_enable && mode == ascending_boundary_mode
		&& in_bin[1:0] == 2'b10 |-> meas.primary >= lim_hi[0])
		else $error("bin 2 low edge not taken from bin 1 high");

endmodule // component_bin_sorter

// *** sorter_pkg.sv ***
// Constants, types and register map shared by the component bin sorter
// What this block does
// [RQ1] Three primary modes: percent, value, ascending boundaries
// [RQ2] Deviation modes measure against the configured center value
// [RQ3] Ascending mode stores center value but ignores it
// [RQ4] One enable switches all classification on or off
// [RQ5] Nine primary bins, one secondary pair, reject result
// [RQ6] No secondary limits: primary result alone decides
// [RQ7] Secondary fail, extra bin off: reject result
// [RQ8] Extra bin on, primary misses all: reject
// [RQ9] Extra bin on, primary hit, secondary fail: extra bin
// [RQ10] Lower secondary only: at or below fails
// [RQ11] Upper secondary only: at or above fails
// [RQ12] Deviation entry sets low -|v|, high +|v|
// [RQ13] Ascending bins 2..9 take previous high as low
// [RQ14] Software orders deviation bins narrowest to widest
// [RQ15] Software enters ascending boundaries in increasing order
// [RQ16] First matching bin in ascending number wins
// [RQ17] Disabled sorter gives no bin decision
package sorter_pkg;

	localparam int ADDR_W = 8;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] CTRL_ADDR     = 8'h00;
	localparam logic [ADDR_W-1:0] CENTER_ADDR   = 8'h04;
	localparam logic [ADDR_W-1:0] SEC_LO_ADDR   = 8'h08;
	localparam logic [ADDR_W-1:0] SEC_HI_ADDR   = 8'h0C;
	localparam logic [ADDR_W-1:0] STATUS_ADDR   = 8'h10;
	localparam logic [ADDR_W-1:0] LIM_BASE_ADDR = 8'h40;

	// Decoded register indices; bin limits start at LIM_IDX
	localparam logic [5:0] CTRL_IDX   = 6'h00;
	localparam logic [5:0] CENTER_IDX = 6'h01;
	localparam logic [5:0] SEC_LO_IDX = 6'h02;
	localparam logic [5:0] SEC_HI_IDX = 6'h03;
	localparam logic [5:0] STATUS_IDX = 6'h04;
	localparam logic [5:0] LIM_IDX    = 6'h10;
	localparam logic [5:0] BAD_IDX    = 6'h3F;

	// Control register fields
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_ENABLE    = 2;
	localparam int CTRL_AUX       = 3;
	localparam int CTRL_SEC_LO    = 4;
	localparam int CTRL_SEC_HI    = 5;
	localparam int CTRL_COUNT_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0900;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Result codes on the handler side
	localparam logic [3:0] NO_BIN        = 4'h0;
	localparam logic [3:0] REJECT_RESULT = 4'hA;
	localparam logic [3:0] SEC_FAIL_BIN  = 4'hB;

	// Percent limits are in hundredths of a percent: 100 % reads 10000
	localparam logic signed [15:0] PCT_FULL = 16'sh2710;

	typedef enum logic [1:0] {
		percent_deviation_mode  = 2'b00,
		value_deviation_mode    = 2'b01,
		ascending_boundary_mode = 2'b10
	} limit_mode_t;

	typedef struct packed {
		logic signed [31:0] primary;
		logic signed [31:0] secondary;
	} meas_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] bin;
	} result_t;

endpackage

// *** meas_engine.sv ***
// Measurement engine and handler model facing the sorter
module meas_engine
	import sorter_pkg::*;
(
	// Clock
	input  wire logic    aclk,
	// Measurement to the sorter
	output logic         meas_valid,
	output meas_t        meas,
	// Decision from the sorter
	input  wire result_t decision
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle at time zero
	initial begin
		meas_valid = 1'b0;
		meas       = '0;
	end

	// One strobe or two back to back; decision read one edge after each take
	task automatic run(input meas_t m0, input meas_t m1, input bit two,
		output result_t d0, output result_t d1);
		meas_valid <= 1'b1;
		meas       <= m0;
		@(posedge aclk);
		if (two) begin
			meas <= m1;
			@(posedge aclk);
			d0 = decision;
		end
		// Idle bus shows the inverse so a stale value is never mistaken for data
		meas_valid <= 1'b0;
		meas       <= two ? ~m1 : ~m0;
		@(posedge aclk);
		if (two) begin
			d1 = decision;
		end else begin
			d0 = decision;
		end
	endtask
endmodule // meas_engine

// *** component_bin_sorter_test.sv ***
// Self-checking bench for the component bin sorter
module component_bin_sorter_test
	import sorter_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct {
		logic [7:0]         ctrl;
		logic signed [31:0] center;
		logic signed [31:0] prim;
		logic signed [31:0] sec;
		logic [3:0]         bin;
	} row_t;

	logic              aclk, aresetn, ce, awvalid, awready, wvalid, wready;
	logic              bvalid, bready, arvalid, arready, rvalid, rready, meas_valid;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata;
	logic [3:0]        wstrb;
	logic [2:0]        awprot, arprot;
	logic [1:0]        bresp, rresp;
	meas_t             meas;
	result_t           decision;
	int                mismatches;
	int                checked;

	// Ctrl low byte, center, primary, secondary, expected bin
	row_t rows [24] = '{
		'{8'h05, 1000, 1000, 0, 4'h1}, '{8'h05, 1000, 1010, 0, 4'h1},
		'{8'h05, 1000, 1011, 0, 4'h2}, '{8'h05, 1000, 990, 0, 4'h1},
		'{8'h05, 1000, 1090, 0, 4'h9}, '{8'h05, 2000, 2005, 0, 4'h1},
		'{8'h05, 1000, 1091, 0, 4'hA}, '{8'h35, 1000, 1000, 50, 4'h1},
		'{8'h35, 1000, 1000, 100, 4'hA}, '{8'h35, 1000, 1000, 0, 4'hA},
		'{8'h3D, 1000, 1000, 100, 4'hB}, '{8'h3D, 1000, 1091, 100, 4'hA},
		'{8'h1D, 1000, 1000, 0, 4'hB}, '{8'h1D, 1000, 1000, 1, 4'h1},
		'{8'h2D, 1000, 1000, 100, 4'hB}, '{8'h2D, 1000, 1000, -500, 4'h1},
		'{8'h04, 1000, 1001, 0, 4'h1}, '{8'h04, 1000, 1002, 0, 4'h2},
		'{8'h04, 1000, 1009, 0, 4'h9}, '{8'h04, 1000, 1010, 0, 4'hA},
		'{8'h06, 1000, 0, 0, 4'h1}, '{8'h06, 5, 100, 0, 4'h1},
		'{8'h06, 5, 150, 0, 4'h2}, '{8'h06, 5, 901, 0, 4'hA}
	};

	// Clock, 5 ns period
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	component_bin_sorter i_dut (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.meas_valid(meas_valid), .meas(meas), .decision(decision)
	);

	meas_engine i_engine (
		.aclk(aclk), .meas_valid(meas_valid), .meas(meas), .decision(decision)
	);

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		bit aw_done;
		bit w_done;
		aw_done = 0;
		w_done  = 0;
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		bready  <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (bvalid) break;
			if (awready && !aw_done) begin
				aw_done = 1;
				awvalid <= 1'b0;
			end
			if (wready && !w_done) begin
				w_done = 1;
				wvalid <= 1'b0;
			end
		end
		// Ready stays high between calls so it is never driven twice in one step
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		if (n == 64) begin
			mismatches++;
			end_of_test();
		end
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		bit ar_done;
		ar_done = 0;
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (rvalid) break;
			if (arready && !ar_done) begin
				ar_done = 1;
				arvalid <= 1'b0;
			end
		end
		chk("rdata", ed, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		if (n == 64) begin
			mismatches++;
			end_of_test();
		end
	endtask

	initial begin
		row_t    r;
		result_t d0;
		result_t d1;
		bit      asc_done;
		int      i;
		int      j;
		aresetn = 1'b0;
		ce      = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, awprot, arprot} = '0;
		wstrb = 4'hF;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// Reset values and map holes
		chk("decision", 32'h0, {27'h0, decision});
		axi_rd(CTRL_ADDR, 32'h0000_0900, RESP_OKAY);
		axi_rd(CENTER_ADDR, 32'h0, RESP_OKAY);
		axi_rd(8'h20, 32'h0, RESP_SLVERR);
		axi_wr(STATUS_ADDR, 32'h0, RESP_SLVERR);
		$display("test reset and map done");
		// Deviation bins, narrow to wide, entered negative to test the magnitude
		for (i = 0; i < 9; i++) begin
			axi_wr(LIM_BASE_ADDR + 8'(8 * i), -(10 * (i + 1)), RESP_OKAY);
		end
		axi_rd(LIM_BASE_ADDR, 32'hFFFF_FFF6, RESP_OKAY);
		axi_rd(8'h44, 32'h0000_000A, RESP_OKAY);
		axi_wr(SEC_LO_ADDR, 32'h0, RESP_OKAY);
		axi_wr(SEC_HI_ADDR, 32'h0000_0064, RESP_OKAY);
		asc_done = 0;
		for (i = 0; i < 24; i++) begin
			r = rows[i];
			axi_wr(CTRL_ADDR, {24'h00_0009, r.ctrl}, RESP_OKAY);
			axi_wr(CENTER_ADDR, r.center, RESP_OKAY);
			if (r.ctrl[1:0] == 2'b10 && !asc_done) begin
				asc_done = 1;
				axi_wr(LIM_BASE_ADDR, 32'h0, RESP_OKAY);
				// Bin 2 low written off-boundary: it must not be used
				axi_wr(8'h48, 32'h0000_01F4, RESP_OKAY);
				for (j = 0; j < 9; j++) begin
					axi_wr(8'h44 + 8'(8 * j), 100 * (j + 1), RESP_OKAY);
				end
			end
			i_engine.run({r.prim, r.sec}, '0, 1'b0, d0, d1);
			chk("decision", {27'h0, 1'b1, r.bin},
				{27'h0, d0});
		end
		$display("test table done");
		// Disabled: no pulse, bin holds, status shows the held bin
		axi_wr(CTRL_ADDR, 32'h0000_0902, RESP_OKAY);
		i_engine.run({32'sd50, 32'sd0}, '0, 1'b0, d0, d1);
		chk("disabled", {27'h0, 1'b0, rows[23].bin}, {27'h0, d0});
		axi_rd(STATUS_ADDR, {27'h000_0000, 1'b0, REJECT_RESULT}, RESP_OKAY);
		$display("test disable done");
		// Two measurements on consecutive cycles
		axi_wr(CTRL_ADDR, 32'h0000_0906, RESP_OKAY);
		i_engine.run({32'sd50, 32'sd0}, {32'sd250, 32'sd0}, 1'b1, d0, d1);
		chk("first", 32'h0000_0011, {27'h0, d0});
		chk("second", 32'h0000_0013, {27'h0, d1});
		$display("test back to back done");
		// Clock enable low: the strobe is not taken and the last bin holds
		ce <= 1'b0;
		i_engine.run({32'sd50, 32'sd0}, '0, 1'b0, d0, d1);
		ce <= 1'b1;
		chk("frozen", 32'h0000_0003, {27'h0, d0});
		$display("test clock enable done");
		// Reset in mid-run
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("decision", 32'h0, {27'h0, decision});
		axi_rd(CTRL_ADDR, 32'h0000_0900, RESP_OKAY);
		$display("test second reset done");
		end_of_test();
	end
endmodule // component_bin_sorter_test
